// [asrm_top.sv]
// Operation
// - Continuous mode converts every enabled channel in turn, round robin, at a tick of 10 MHz at most.
// - One channel takes at least 18 ticks, more with open and sampling delays and averaging.
// - Results go into a 64-word FIFO, and a result arriving while it is full is an overflow.
// - With range checking on, a result above the high or below the low threshold raises the range interrupt.
// - Range checking works the same in continuous and single-shot mode.
// - The end of each full round of channels raises the round interrupt for CPU draining.
// - Each channel has its own range-check enable and only enabled channels are compared.
// - One high and one low threshold are shared by every channel.
// - After an overflow further results are lost until conversion is restarted, nothing else is upset.
// - A programmable prescaler divides the system clock down to the converter tick, and so to the wanted sampling rate.
// - Sixteen-sample averaging with minimum delays gives one result per 273 ticks.
module asrm_top #(
  parameter int NCH = asrm_pkg::NCH,
  parameter int RES_W = asrm_pkg::RES_W,
  parameter int DEPTH = asrm_pkg::FIFO_DEPTH
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [RES_W-1:0] ADC_RESULT,
  output logic [$clog2(NCH)-1:0] ADC_CHAN,
  output logic ADC_SAMPLE,
  output logic FIFO_VALID,
  output logic [asrm_pkg::WORD_W-1:0] FIFO_DATA,
  input wire logic FIFO_READY,
  output logic IRQ_ROUND,
  output logic IRQ_RANGE
);
  localparam int CW = $clog2(NCH);
  localparam int AW = $clog2(DEPTH);
  localparam int ACC_W = RES_W + asrm_pkg::AVG_MAX_SH;
  localparam logic [7:0] DIV_FLOOR = 8'(asrm_pkg::MIN_DIV - 1);
  localparam logic [7:0] CONV_LAST = 8'(asrm_pkg::CONV_TICKS - 1);

  // Next enabled channel after cur; top bit marks a wrap past the last one
  function automatic logic [CW:0] next_chan(input logic [NCH-1:0] en, input logic [CW-1:0] cur);
    logic [CW:0] res;
    logic found;
    logic [CW-1:0] idx;
    res = {1'b1, cur};
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = CW'((int'(cur) + i) % NCH);
      if (!found && en[idx]) begin
        found = 1'b1;
        res = {(int'(cur) + i) >= NCH, idx};
      end
    end
    return res;
  endfunction : next_chan

  logic [3:0] ctrl_reg;
  logic [NCH-1:0] chen_reg;
  logic [NCH-1:0] rngen_reg;
  logic [31:0] thr_reg;
  logic [31:0] tim_reg;
  logic ovf_flag_reg;
  logic round_flag_reg;
  logic range_flag_reg;
  logic ovf_lock_reg;
  logic wr_pend_reg;
  logic [7:0] wr_off_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic [7:0] div_reg;
  asrm_pkg::asrm_state_e st_reg;
  asrm_pkg::asrm_state_e st_next;
  logic [7:0] tcnt_reg;
  logic [CW-1:0] ch_reg;
  logic [4:0] smp_reg;
  logic [ACC_W-1:0] acc_reg;
  logic adc_sample_reg;
  logic irq_round_reg;
  logic irq_range_reg;
  logic [8:0] tick_cnt_reg;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [asrm_pkg::WORD_W-1:0] fifo_data;
  logic [AW:0] fifo_count;

  // Bus address phase decode; whole words only, so size is not decoded
  wire ap_valid = HSEL && HREADY && HTRANS[1];
  wire [7:0] ap_off = HADDR[7:0];
  wire ap_rd = ap_valid && !HWRITE;
  wire wr_ctrl = wr_pend_reg && (wr_off_reg == asrm_pkg::CTRL_OFF);
  wire wr_chen = wr_pend_reg && (wr_off_reg == asrm_pkg::CHEN_OFF);
  wire wr_rngen = wr_pend_reg && (wr_off_reg == asrm_pkg::RNGEN_OFF);
  wire wr_thr = wr_pend_reg && (wr_off_reg == asrm_pkg::THR_OFF);
  wire wr_tim = wr_pend_reg && (wr_off_reg == asrm_pkg::TIM_OFF);
  wire wr_stat = wr_pend_reg && (wr_off_reg == asrm_pkg::STAT_OFF);
  wire cpu_pop = ap_rd && (ap_off == asrm_pkg::DATA_OFF);

  // Configuration fields
  wire en = ctrl_reg[asrm_pkg::CTRL_EN_BIT];
  wire cont = ctrl_reg[asrm_pkg::CTRL_CONT_BIT];
  wire [RES_W-1:0] thr_lo = thr_reg[asrm_pkg::THR_LO_LSB +: RES_W];
  wire [RES_W-1:0] thr_hi = thr_reg[asrm_pkg::THR_HI_LSB +: RES_W];
  wire [7:0] open_dly = tim_reg[asrm_pkg::TIM_OPEN_LSB +: 8];
  wire [7:0] smp_dly = tim_reg[asrm_pkg::TIM_SMP_LSB +: 8];
  wire [2:0] avg_fld = tim_reg[asrm_pkg::TIM_AVG_LSB +: 3];
  wire [7:0] presc = tim_reg[asrm_pkg::TIM_PRE_LSB +: 8];
  wire [2:0] avg_sh = (avg_fld > 3'(asrm_pkg::AVG_MAX_SH)) ? 3'(asrm_pkg::AVG_MAX_SH) : avg_fld;
  wire [4:0] n_smp = 5'h01 << avg_sh;

  // Prescaler: the floor keeps the converter tick at or under its ceiling
  wire [7:0] div_max = (presc < DIV_FLOOR) ? DIV_FLOOR : presc;
  wire tick = CE && (div_reg >= div_max);

  // Sequencer decisions
  wire [CW:0] first_ch = next_chan(chen_reg, CW'(NCH - 1));
  wire [CW:0] after_ch = next_chan(chen_reg, ch_reg);
  wire go = en && (chen_reg != '0);
  wire store_tick = tick && (st_reg == asrm_pkg::ST_STORE);
  wire conv_done = tick && (st_reg == asrm_pkg::ST_CONV) && (tcnt_reg == '0);
  wire last_smp = (smp_reg + 5'h01) == n_smp;
  wire round_end = store_tick && after_ch[CW];
  wire shot_end = round_end && !cont;
  wire keep_on = go && !shot_end;
  asrm_pkg::asrm_state_e start_st;
  assign start_st = (open_dly != '0) ? asrm_pkg::ST_OPEN : asrm_pkg::ST_SAMPLE;
  wire [ACC_W-1:0] acc_sum = acc_reg + ACC_W'(ADC_RESULT);

  // Averaged result and range compare, with no term for the conversion mode
  wire [RES_W-1:0] avg_res = RES_W'(acc_reg >> avg_sh);
  wire out_rng = (avg_res > thr_hi) || (avg_res < thr_lo);
  wire rng_hit = store_tick && rngen_reg[ch_reg] && out_rng;

  // Result word into the FIFO; a full FIFO is an overflow, later words drop
  wire push_req = store_tick && !ovf_lock_reg;
  wire fifo_push = push_req && fifo_in_ready;
  wire ovf_evt = push_req && !fifo_in_ready;
  wire [asrm_pkg::WORD_W-1:0] word_in = {4'(ch_reg), 12'(avg_res)};
  wire fifo_pop = fifo_valid && (FIFO_READY || cpu_pop);

  // Sticky flags: a hardware set beats a software write-one clear
  wire ovf_next = (ovf_flag_reg && !(wr_stat && HWDATA[asrm_pkg::STAT_OVF_BIT])) || ovf_evt;
  wire round_next = (round_flag_reg && !(wr_stat && HWDATA[asrm_pkg::STAT_ROUND_BIT])) || round_end;
  wire range_next = (range_flag_reg && !(wr_stat && HWDATA[asrm_pkg::STAT_RANGE_BIT])) || rng_hit;
  // The lock holds until the enable drops, by software (the restart step) or at a single-shot end
  wire lock_next = (ovf_lock_reg && en) || ovf_evt;

  // Read data, captured in the address phase so HRDATA is a register
  wire [31:0] stat_word = {{(24 - AW - 1){1'b0}}, fifo_count, 4'h0, range_flag_reg,
                           round_flag_reg, ovf_flag_reg, st_reg != asrm_pkg::ST_IDLE};
  // An empty FIFO reads as zero, never a stale or unwritten slot
  wire [asrm_pkg::WORD_W-1:0] pop_word = fifo_valid ? fifo_data : '0;
  wire [31:0] rd_mux =
    (ap_off == asrm_pkg::CTRL_OFF) ? {28'h0, ctrl_reg} :
    (ap_off == asrm_pkg::CHEN_OFF) ? 32'(chen_reg) :
    (ap_off == asrm_pkg::RNGEN_OFF) ? 32'(rngen_reg) :
    (ap_off == asrm_pkg::THR_OFF) ? thr_reg :
    (ap_off == asrm_pkg::TIM_OFF) ? tim_reg :
    (ap_off == asrm_pkg::STAT_OFF) ? stat_word :
    (ap_off == asrm_pkg::DATA_OFF) ? {fifo_valid, 15'h0, pop_word} : 32'h0;

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hready_reg;
  assign HRESP = 1'b0;
  assign ADC_CHAN = ch_reg;
  assign ADC_SAMPLE = adc_sample_reg;
  assign IRQ_ROUND = irq_round_reg;
  assign IRQ_RANGE = irq_range_reg;

  // Bus slave pipeline: zero wait states, OKAY on every access
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg <= '0;
      hrdata_reg <= '0;
      hready_reg <= 1'b1;
    end else if (CE) begin
      wr_pend_reg <= ap_valid && HWRITE;
      wr_off_reg <= ap_off;
      hrdata_reg <= ap_rd ? rd_mux : hrdata_reg;
      hready_reg <= 1'b1;
    end
  end

  // Software registers; single shot clears its own enable, a write wins
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= asrm_pkg::CTRL_RST;
      chen_reg <= asrm_pkg::CHEN_RST;
      rngen_reg <= asrm_pkg::RNGEN_RST;
      thr_reg <= asrm_pkg::THR_RST;
      tim_reg <= asrm_pkg::TIM_RST;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_reg <= HWDATA[3:0];
      end else if (shot_end) begin
        ctrl_reg[asrm_pkg::CTRL_EN_BIT] <= 1'b0;
      end
      chen_reg <= wr_chen ? HWDATA[NCH-1:0] : chen_reg;
      rngen_reg <= wr_rngen ? HWDATA[NCH-1:0] : rngen_reg;
      thr_reg <= wr_thr ? HWDATA : thr_reg;
      tim_reg <= wr_tim ? HWDATA : tim_reg;
    end
  end

  // Flags, overflow lock and interrupt lines
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_flag_reg <= 1'b0;
      round_flag_reg <= 1'b0;
      range_flag_reg <= 1'b0;
      ovf_lock_reg <= 1'b0;
      irq_round_reg <= 1'b0;
      irq_range_reg <= 1'b0;
    end else if (CE) begin
      ovf_flag_reg <= ovf_next;
      round_flag_reg <= round_next;
      range_flag_reg <= range_next;
      ovf_lock_reg <= lock_next;
      irq_round_reg <= round_next && ctrl_reg[asrm_pkg::CTRL_RIE_BIT];
      irq_range_reg <= range_next && ctrl_reg[asrm_pkg::CTRL_QIE_BIT];
    end
  end

  // Next state; dropping the enable abandons the channel at the next tick
  always_comb begin
    st_next = st_reg;
    if (tick) begin
      case (st_reg)
        asrm_pkg::ST_IDLE: st_next = go ? start_st : asrm_pkg::ST_IDLE;
        asrm_pkg::ST_OPEN: st_next = (tcnt_reg == '0) ? asrm_pkg::ST_SAMPLE : st_reg;
        asrm_pkg::ST_SAMPLE: st_next = (tcnt_reg == '0) ? asrm_pkg::ST_CONV : st_reg;
        asrm_pkg::ST_CONV: begin
          if (tcnt_reg == '0) begin
            st_next = last_smp ? asrm_pkg::ST_STORE : start_st;
          end
        end
        asrm_pkg::ST_STORE: st_next = keep_on ? start_st : asrm_pkg::ST_IDLE;
        default: st_next = asrm_pkg::ST_IDLE;
      endcase
      if (!go) begin
        st_next = asrm_pkg::ST_IDLE;
      end
    end
  end

  // Tick divider and phase timer; each sample is delays plus 17 ticks
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= '0;
      tcnt_reg <= '0;
    end else if (CE) begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick) begin
        if (st_next != st_reg || st_reg == asrm_pkg::ST_STORE) begin
          case (st_next)
            asrm_pkg::ST_OPEN: tcnt_reg <= open_dly - 8'h01;
            asrm_pkg::ST_SAMPLE: tcnt_reg <= smp_dly;
            asrm_pkg::ST_CONV: tcnt_reg <= CONV_LAST;
            default: tcnt_reg <= '0;
          endcase
        end else if (tcnt_reg != '0) begin
          tcnt_reg <= tcnt_reg - 8'h01;
        end
      end
    end
  end

  // Channel, sample count and accumulator
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= asrm_pkg::ST_IDLE;
      ch_reg <= '0;
      smp_reg <= '0;
      acc_reg <= '0;
      adc_sample_reg <= 1'b0;
    end else if (CE) begin
      st_reg <= st_next;
      adc_sample_reg <= st_next == asrm_pkg::ST_SAMPLE;
      if (tick && st_reg == asrm_pkg::ST_IDLE) begin
        ch_reg <= first_ch[CW-1:0];
        smp_reg <= '0;
        acc_reg <= '0;
      end else if (store_tick) begin
        ch_reg <= after_ch[CW-1:0];
        smp_reg <= '0;
        acc_reg <= '0;
      end else if (conv_done) begin
        smp_reg <= smp_reg + 5'h01;
        acc_reg <= acc_sum;
      end
    end
  end

  asrm_fifo #(
    .W(asrm_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .en(CE),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(word_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );
  assign FIFO_VALID = fifo_valid;
  assign FIFO_DATA = fifo_data;

  // Ticks spent in one channel's sample phases, read only by the checks
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      if (st_reg == asrm_pkg::ST_IDLE || st_reg == asrm_pkg::ST_STORE) begin
        tick_cnt_reg <= '0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 9'h001;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_tick_rate: assert property (tick |=> !tick)
    else $error("Converter tick faster than its ceiling");
  a_min_channel: assert property (store_tick |-> tick_cnt_reg >= 9'(asrm_pkg::MIN_CHAN_TICKS - 1))
    else $error("Channel finished in fewer ticks than allowed");
  a_avg16_len: assert property ((store_tick && avg_sh == 3'h4 && open_dly == '0 && smp_dly == '0)
    |-> tick_cnt_reg == 9'(asrm_pkg::AVG16_TICKS - 1))
    else $error("Sixteen-sample channel not 273 ticks");
  a_ovf_flag: assert property (ovf_evt |=> ovf_flag_reg && ovf_lock_reg)
    else $error("Overflow not flagged");
  a_ovf_drop: assert property (ovf_lock_reg |=> fifo_count <= $past(fifo_count))
    else $error("Result stored after overflow");
  a_range_set: assert property (rng_hit |=> range_flag_reg)
    else $error("Out of range result not flagged");
  a_range_gate: assert property ((store_tick && !rngen_reg[ch_reg]) |=>
    !$rose(range_flag_reg))
    else $error("Disabled channel raised range flag");
  a_round_set: assert property (round_end |=> round_flag_reg)
    else $error("Round end not flagged");
  a_rr_order: assert property ((store_tick && go && !after_ch[CW]) |=> ch_reg > $past(ch_reg))
    else $error("Channel order not round robin");

  c_overflow: cover property (ovf_evt);
  c_range_hit: cover property (rng_hit);
  c_round_done: cover property (round_end ##1 !en);
  c_avg16: cover property (store_tick && avg_sh == 3'h4);
endmodule : asrm_top

// [asrm_pkg.sv]
package asrm_pkg;
  // Clock rates in Hz; the converter tick may never run above its ceiling
  localparam int SYS_HZ = 20_000_000;
  localparam int ADC_MAX_HZ = 10_000_000;
  localparam int MIN_DIV = (SYS_HZ + ADC_MAX_HZ - 1) / ADC_MAX_HZ;
  localparam int NCH = 8;
  localparam int RES_W = 12;
  localparam int FIFO_DEPTH = 64;
  localparam int WORD_W = 16;
  // Converter ticks: conversion phase, shortest channel, 16-sample channel
  localparam int CONV_TICKS = 16;
  localparam int MIN_CHAN_TICKS = 18;
  localparam int AVG16_TICKS = 273;
  localparam int AVG_MAX_SH = 4;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CHEN_OFF = 8'h04;
  localparam logic [7:0] RNGEN_OFF = 8'h08;
  localparam logic [7:0] THR_OFF = 8'h0c;
  localparam logic [7:0] TIM_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] DATA_OFF = 8'h18;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_RIE_BIT = 2;
  localparam int CTRL_QIE_BIT = 3;
  localparam int THR_LO_LSB = 0;
  localparam int THR_HI_LSB = 16;
  localparam int TIM_OPEN_LSB = 0;
  localparam int TIM_SMP_LSB = 8;
  localparam int TIM_AVG_LSB = 16;
  localparam int TIM_PRE_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_ROUND_BIT = 2;
  localparam int STAT_RANGE_BIT = 3;
  localparam int STAT_CNT_LSB = 8;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] CHEN_RST = 8'hff;
  localparam logic [7:0] RNGEN_RST = 8'h00;
  localparam logic [31:0] THR_RST = 32'h0fff0000;
  localparam logic [31:0] TIM_RST = 32'h00000000;

  // Sequencer states, Gray coded along idle-open-sample-convert-store
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPEN = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_CONV = 3'h2,
    ST_STORE = 3'h6
  } asrm_state_e;
endpackage : asrm_pkg

// [asrm_fifo.sv]
module asrm_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic valid_reg;
  logic [W-1:0] data_reg;

  // Handshakes and next pointers
  wire push = in_valid && in_ready;
  wire pop = valid_reg && out_ready;
  wire [AW-1:0] rd_ptr_next = rd_ptr_reg + AW'(pop);
  wire [AW:0] count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  // A word written into the head slot must bypass the array
  wire bypass = push && (wr_ptr_reg == rd_ptr_next);

  assign in_ready = count_reg != FULL_CNT;
  assign out_valid = valid_reg;
  assign out_data = data_reg;
  assign count = count_reg;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (en && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, level and registered head word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= '0;
    end else if (en) begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      valid_reg <= count_next != '0;
      data_reg <= bypass ? in_data : mem[rd_ptr_next];
    end
  end
endmodule : asrm_fifo

// [asrm_drain_model.sv]
module asrm_drain_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic valid,
  input wire logic [15:0] data,
  output logic ready,
  output int n_words
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] words [$];

  // DMA sink: take the head word at the edge, ready lags stall by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      n_words <= 0;
      words.delete();
    end else begin
      if (valid && ready) begin
        words.push_back(data);
        n_words <= n_words + 1;
      end
      ready <= !stall;
    end
  end
endmodule : asrm_drain_model

// [tb_adc_sequencer_range_monitor.sv]
module tb_adc_sequencer_range_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, ADC_SAMPLE;
  logic FIFO_VALID, FIFO_READY, IRQ_ROUND, IRQ_RANGE, stall, ce;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, ADC_CHAN;
  logic [11:0] ADC_RESULT;
  logic [15:0] FIFO_DATA;
  logic [11:0] level [8] = '{12'h050, 12'h900, 12'h400, 12'h800, 12'h100, 12'h7ff, 12'h3c3, 12'h123};
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
  logic [31:0] rstv [6] = '{32'h0, 32'hff, 32'h0, 32'h0fff0000, 32'h0, 32'h0};
  int errors = 0;
  int n_checks = 0;
  int n_words, gap, n_hi;

  asrm_top i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(ce), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ADC_RESULT(ADC_RESULT),
    .ADC_CHAN(ADC_CHAN), .ADC_SAMPLE(ADC_SAMPLE), .FIFO_VALID(FIFO_VALID),
    .FIFO_DATA(FIFO_DATA), .FIFO_READY(FIFO_READY), .IRQ_ROUND(IRQ_ROUND),
    .IRQ_RANGE(IRQ_RANGE));
  asrm_drain_model i_dma (.clk(SYS_CLK), .rst_n(RST_N), .stall(stall), .valid(FIFO_VALID),
    .data(FIFO_DATA), .ready(FIFO_READY), .n_words(n_words));

  // 20 MHz system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  // Converter front end: a fixed level per channel
  always @(posedge SYS_CLK) ADC_RESULT <= level[ADC_CHAN];

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // A wait that ran out ends the run
  task automatic quit(input string what);
    errors++;
    $display("ERROR %s expected done seen timeout", what);
    test_done();
  endtask : quit

  // Next edge with hready high, bounded
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 16);
    if (HREADYOUT !== 1'b1) quit("hready");
  endtask : rdy

  // One AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h000000, a};
    HWRITE <= wr;
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    rdy();
    rd = HRDATA;
  endtask : bus

  // Wait for the sink to hold n words; gap gets the cycles spent, n_hi those sampling
  task automatic wait_words(input int n);
    gap = 0;
    n_hi = 0;
    while (n_words < n) begin
      @(posedge SYS_CLK);
      gap++;
      if (ADC_SAMPLE === 1'b1) n_hi++;
      if (gap > 30000) quit("words");
    end
  endtask : wait_words

  // Reset values and an unmapped offset
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, offs[i], 32'h0);
      check("reset value", rd, rstv[i]);
    end
    check("hresp", HRESP, 1'b0);
  endtask : t_reset

  // Spacing of words from one channel; the first gap includes start-up, so skip it
  task automatic t_pace(input logic [31:0] tim, input int cyc, input int hi);
    int b;
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h10, tim);
    bus(1'b1, 8'h00, 32'h3);
    b = n_words;
    wait_words(b + 2);
    wait_words(b + 3);
    check("word gap", gap, cyc);
    check("sample cycles", n_hi, hi);
    check("word", i_dma.words[b + 2], {4'h3, level[3]});
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_pace

  // A low clock enable freezes the sequencer, so the next word comes that much later
  task automatic t_freeze;
    int b;
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h10, 32'h01000000);
    bus(1'b1, 8'h00, 32'h3);
    b = n_words;
    wait_words(b + 2);
    ce <= 1'b0;
    repeat (100) @(posedge SYS_CLK);
    ce <= 1'b1;
    check("frozen", n_words, b + 2);
    wait_words(b + 3);
    check("thawed gap", gap, 36);
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_freeze

  // Three channels in turn, each word carrying its channel and level
  task automatic t_robin;
    int b;
    logic [3:0] c;
    bus(1'b1, 8'h04, 32'h25);
    bus(1'b1, 8'h10, 32'h01000000);
    bus(1'b1, 8'h00, 32'h3);
    b = n_words;
    wait_words(b + 7);
    bus(1'b1, 8'h00, 32'h0);
    for (int i = b + 1; i < b + 7; i++) begin
      c = i_dma.words[i - 1][15:12];
      check("chan", i_dma.words[i][15:12], c == 4'h0 ? 4'h2 : c == 4'h2 ? 4'h5 : 4'h0);
      check("data", i_dma.words[i][11:0], level[i_dma.words[i][14:12]]);
    end
  endtask : t_robin

  // Single shot round, CPU draining through the data register
  task automatic t_round;
    int k;
    stall <= 1'b1;
    bus(1'b1, 8'h14, 32'hf);
    bus(1'b1, 8'h04, 32'h03);
    bus(1'b1, 8'h00, 32'h5);
    k = 0;
    while (IRQ_ROUND !== 1'b1) begin
      @(posedge SYS_CLK);
      k++;
      if (k > 500) quit("round irq");
    end
    bus(1'b0, 8'h14, 32'h0);
    check("round count", {rd[14:8], rd[2]}, 8'h05);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'h18, 32'h0);
      check("cpu pop", {rd[31], rd[15:0]}, i < 2 ? {1'b1, 1'b0, i[2:0], level[i]} : 17'h0);
    end
    bus(1'b1, 8'h14, 32'h4);
    bus(1'b0, 8'h14, 32'h0);
    check("round clear", {IRQ_ROUND, rd[2]}, 2'h0);
    stall <= 1'b0;
  endtask : t_round

  // One round of range checking; flag and interrupt compared with the expectation
  task automatic t_range(input logic [31:0] ctrl, input logic [7:0] chen, input logic [7:0] rng,
      input logic exp);
    int b;
    bus(1'b1, 8'h14, 32'hf);
    bus(1'b1, 8'h08, {24'h000000, rng});
    bus(1'b1, 8'h04, {24'h000000, chen});
    bus(1'b1, 8'h00, ctrl);
    b = n_words;
    wait_words(b + $countones(chen));
    bus(1'b1, 8'h00, 32'h8);
    bus(1'b0, 8'h14, 32'h0);
    check("range flag", rd[3], exp);
    check("range irq", IRQ_RANGE, exp);
  endtask : t_range

  // Fill until overflow, then words stay lost until the restart sequence
  task automatic t_ovf;
    int b, k;
    stall <= 1'b1;
    bus(1'b1, 8'h14, 32'hf);
    bus(1'b1, 8'h04, 32'h01);
    bus(1'b1, 8'h00, 32'h3);
    k = 0;
    do begin
      bus(1'b0, 8'h14, 32'h0);
      k++;
      if (k > 1500) quit("overflow");
    end while (rd[1] !== 1'b1);
    check("full count", rd[14:8], 7'h40);
    b = n_words;
    stall <= 1'b0;
    wait_words(b + 64);
    repeat (4 * 36) @(posedge SYS_CLK);
    check("lost words", n_words, b + 64);
    bus(1'b0, 8'h14, 32'h0);
    check("busy ovf", rd[1:0], 2'h3);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h14, 32'h2);
    bus(1'b0, 8'h14, 32'h0);
    check("ovf clear", rd[1], 1'b0);
    bus(1'b1, 8'h00, 32'h3);
    wait_words(b + 65);
    check("resumed", i_dma.words[b + 64], {4'h0, level[0]});
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_ovf

  // Main sequence
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    ADC_RESULT = 12'h000;
    stall = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_pace(32'h01000000, 36, 2);
    t_pace(32'h03000000, 72, 4);
    t_pace(32'h01000102, 42, 4);
    t_pace(32'h01040000, 546, 32);
    t_pace(32'h01010000, 70, 4);
    t_freeze();
    t_robin();
    t_round();
    bus(1'b1, 8'h0c, 32'h08000100);
    t_range(32'h9, 8'h01, 8'h01, 1'b1);
    t_range(32'hb, 8'h01, 8'h01, 1'b1);
    t_range(32'h9, 8'h02, 8'h02, 1'b1);
    t_range(32'h9, 8'h01, 8'h00, 1'b0);
    t_range(32'h9, 8'h1c, 8'h1c, 1'b0);
    t_range(32'hb, 8'h1c, 8'h1c, 1'b0);
    t_ovf();
    test_done();
  end
endmodule : tb_adc_sequencer_range_monitor
